// ### rtl/tsh_pkg.sv
package tsh_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ    = 200;
  localparam int T_IDLE_MS  = 100;
  localparam int T_START_MS = 160;
  localparam int T_WAKE_US  = 100;
  localparam int IDLE_CYC   = T_IDLE_MS * 1000 * CLK_MHZ;
  localparam int START_CYC  = T_START_MS * 1000 * CLK_MHZ;
  localparam int WAKE_CYC   = T_WAKE_US * CLK_MHZ;
  localparam int PWM_PRE    = 64;
  // ----------------------------------------
  // report layout and codes
  // ----------------------------------------
  localparam int         NKEY     = 11;
  localparam int         NIND     = 7;
  localparam int         BYTE_W   = 8;
  localparam logic [2:0] RPT_CNT  = 3'h0;
  localparam logic [2:0] RPT_DET0 = 3'h1;
  localparam logic [2:0] RPT_DETL = 3'h3;
  localparam logic [2:0] RPT_ERR0 = 3'h4;
  localparam logic [2:0] RPT_LAST = 3'h6;
  localparam logic [3:0] NBITS    = 4'h8;
  localparam logic [7:0] CNT_MAX  = 8'hFE;
  localparam logic [1:0] DET_IDLE = 2'h0;
  localparam logic [1:0] DET_TCH  = 2'h1;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_CHAN = 2'h2;
  localparam logic [1:0] CODE_OFF = 2'h3;
  localparam logic [1:0] CODE_RSV = 2'h0;
  localparam logic [3:0] LVL_MAX  = 4'h8;
  // ----------------------------------------
  // commands
  // ----------------------------------------
  localparam logic [7:0] CMD_STORE = 8'h0A;
  localparam logic [7:0] CMD_FULL  = 8'h36;
  localparam logic [7:0] CMD_CAL   = 8'h03;
  localparam logic [7:0] CMD_RESET = 8'h04;
  localparam logic [7:0] CMD_SLEEP = 8'h05;
  localparam logic [7:0] CMD_ALL   = 8'hC1;
  localparam logic [7:0] IDLE_CODE = 8'h55;
  // ----------------------------------------
  // synchroniser bit positions
  // ----------------------------------------
  localparam int SY_SCK  = 0;
  localparam int SY_SS   = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_CHG  = 3;
  localparam int SY_RST  = 4;
  localparam int NSYNC   = 5;

  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10,
    ST_WAKE  = 2'b11
  } tsh_state_e;

  typedef struct packed {
    logic [NKEY-1:0] det;
    logic [NKEY-1:0] err;
    logic [NKEY-1:0] en;
  } tsh_keys_s;

  typedef struct packed {
    logic fast_cfg;
    logic touch_mode;
    logic mode11;
    logic trig_sel;
    logic auto_recal;
    logic standalone;
  } tsh_cfg_s;
endpackage

// ### rtl/tsh_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tsh_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(D);
  localparam logic [AW-1:0] LASTP = AW'(D - 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } tsh_fifo_s;

  tsh_fifo_s q, d;
  logic push, pop;

  // honest flags straight from the fill count
  assign in_ready  = (q.cnt != FULL);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d    = q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == LASTP) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == LASTP) ? '0 : q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  fifo_keep_a: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_data))
    else $error("fifo head lost while waiting");
endmodule
`default_nettype wire

// ### rtl/tsh_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module tsh_host_port #(
  parameter int P_IDLE  = tsh_pkg::IDLE_CYC,
  parameter int P_START = tsh_pkg::START_CYC,
  parameter int P_WAKE  = tsh_pkg::WAKE_CYC,
  parameter int P_PRE   = tsh_pkg::PWM_PRE,
  parameter int FDEPTH  = 4
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // serial pins
  input  wire logic                      sck_i,
  input  wire logic                      ss_n_i,
  input  wire logic                      mosi_i,
  output logic                           miso_o,
  output logic                           miso_oe,
  // status-change line, open drain
  input  wire logic                      chg_i,
  output logic                           chg_o,
  output logic                           chg_oe,
  // hardware reset pin
  input  wire logic                      reset_n_i,
  // configuration and saved settings
  input  wire tsh_pkg::tsh_cfg_s         cfg,
  input  wire logic                      nv_valid,
  input  wire logic                      nv_fast,
  // key measurement
  input  wire tsh_pkg::tsh_keys_s        keys,
  input  wire logic                      key_stuck,
  output logic                           meas_en,
  output logic                           recal,
  // indicators, bit 0 is key_indicator_out_first
  input  wire logic [tsh_pkg::NIND-1:0][3:0] lvl_on,
  input  wire logic [tsh_pkg::NIND-1:0][3:0] lvl_off,
  output logic [tsh_pkg::NIND-1:0]       ind_o,
  output logic [tsh_pkg::NIND-1:0]       ind_oe,
  // status
  output logic                           fast_mode,
  output logic                           mode11,
  output logic                           trig_sel,
  output logic                           spi_ready,
  output logic                           nv_store,
  output logic                           overrun,
  output logic                           asleep
);
  localparam logic [31:0] IDLE_END  = 32'(P_IDLE - 1);
  localparam logic [31:0] START_END = 32'(P_START - 1);
  localparam logic [31:0] WAKE_END  = 32'(P_WAKE - 1);
  localparam logic [15:0] PRE_END   = 16'(P_PRE - 1);

  typedef struct packed {
    tsh_pkg::tsh_state_e        st;
    logic [tsh_pkg::NSYNC-1:0]  s1;
    logic [tsh_pkg::NSYNC-1:0]  s2;
    logic                       sck_p;
    logic                       ss_p;
    logic                       chg_p;
    logic                       fcfg_p;
    logic                       stuck_p;
    logic [7:0]                 sh;
    logic [3:0]                 nb;
    logic                       miso;
    logic                       moe;
    logic [2:0]                 idx;
    logic [7:0]                 rcnt;
    logic                       fast;
    logic [tsh_pkg::NKEY-1:0]   last;
    logic                       chg_oe;
    logic [31:0]                tmr;
    logic [31:0]                gap;
    logic [15:0]                pre;
    logic [2:0]                 pwm;
    logic [tsh_pkg::NIND-1:0]   ind;
    logic [tsh_pkg::NIND-1:0]   ind_oe;
    logic                       meas;
    logic                       recal;
    logic                       store;
    logic                       ovr;
    logic [7:0]                 rxb;
    logic                       rxv;
    logic                       m11;
    logic                       trig;
    logic                       slp;
  } tsh_port_s;

  tsh_port_s                q, d;
  logic                     done;
  logic                     cmd_v;
  logic                     f_ready;
  logic                     f_valid;
  logic [7:0]               cmd;
  logic [tsh_pkg::NKEY-1:0] kd;
  logic                     ss_fall;

  // ----------------------------------------
  // report byte builder
  // ----------------------------------------
  // detect and error bytes share one layout: four pairs, lowest key low
  function automatic logic [7:0] rpt_byte(input logic [2:0] i,
                                          input logic [7:0] c,
                                          input tsh_pkg::tsh_keys_s k);
    logic [7:0] b;
    logic       is_err;
    int         base;
    int         ch;
    b      = '0;
    is_err = (i >= tsh_pkg::RPT_ERR0);
    base   = is_err ? 4 * int'(i - tsh_pkg::RPT_ERR0)
                    : 4 * int'(i - tsh_pkg::RPT_DET0);
    if (i == tsh_pkg::RPT_CNT) begin
      b = c;
    end else begin
      for (int p = 0; p < 4; p++) begin
        ch = base + p;
        if (ch >= tsh_pkg::NKEY) begin
          b[2*p +: 2] = tsh_pkg::CODE_RSV;
        end else if (!k.en[ch]) begin
          b[2*p +: 2] = tsh_pkg::CODE_OFF;
        end else if (is_err) begin
          b[2*p +: 2] = k.err[ch] ? tsh_pkg::ERR_CHAN
                                  : tsh_pkg::ERR_NONE;
        end else begin
          b[2*p +: 2] = k.det[ch] ? tsh_pkg::DET_TCH
                                  : tsh_pkg::DET_IDLE;
        end
      end
    end
    return b;
  endfunction

  assign kd      = keys.det & keys.en;
  assign cmd_v   = f_valid && (q.st == tsh_pkg::ST_RUN);
  assign ss_fall = q.ss_p && !q.s2[tsh_pkg::SY_SS];

  // ----------------------------------------
  // received bytes queue up for the decoder
  // ----------------------------------------
  tsh_fifo #(
    .W (tsh_pkg::BYTE_W),
    .D (FDEPTH)
  ) u_rxq (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (q.rxv),
    .in_ready  (f_ready),
    .in_data   (q.rxb),
    .out_valid (f_valid),
    .out_ready (q.st == tsh_pkg::ST_RUN),
    .out_data  (cmd)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic sck;
    logic ss_n;
    logic [tsh_pkg::NIND-1:0] lvl_hit;
    d       = q;
    done    = 1'b0;
    d.s1    = {reset_n_i, chg_i, mosi_i, ss_n_i, sck_i};
    d.s2    = q.s1;
    sck     = q.s2[tsh_pkg::SY_SCK];
    ss_n    = q.s2[tsh_pkg::SY_SS];
    d.sck_p = sck;
    d.ss_p  = ss_n;
    d.chg_p = q.s2[tsh_pkg::SY_CHG];
    d.fcfg_p  = cfg.fast_cfg;
    d.stuck_p = key_stuck;
    d.recal   = 1'b0;
    d.store   = 1'b0;
    d.rxv     = 1'b0;
    lvl_hit   = '0;
    unique case (q.st)
      tsh_pkg::ST_INIT: begin
        // silent until start-up completes, saved settings applied
        d.moe  = 1'b0;
        d.fast = nv_valid && nv_fast;
        d.idx  = tsh_pkg::RPT_CNT;
        d.rcnt = '0;
        d.ovr  = 1'b0;
        d.last = kd;
        d.tmr  = q.tmr + 32'h1;
        if (q.tmr == START_END) begin
          d.st  = tsh_pkg::ST_RUN;
          d.tmr = '0;
        end
      end
      tsh_pkg::ST_SLEEP: begin
        d.moe = 1'b0;
        if (ss_fall || (q.chg_p && !q.s2[tsh_pkg::SY_CHG])) begin
          d.st  = tsh_pkg::ST_WAKE;
          d.tmr = '0;
        end
      end
      tsh_pkg::ST_WAKE: begin
        // serial traffic is ignored while waking
        d.tmr = q.tmr + 32'h1;
        if (q.tmr == WAKE_END) begin
          d.st = tsh_pkg::ST_RUN;
        end
      end
      tsh_pkg::ST_RUN: begin
        if (cfg.fast_cfg && !q.fcfg_p) begin
          d.fast = 1'b1;
        end
        if (cfg.standalone) begin
          d.moe = 1'b0;
        end else if (ss_n) begin
          d.moe = 1'b0;
          if (q.gap != IDLE_END) begin
            d.gap = q.gap + 32'h1;
          end else begin
            d.idx = tsh_pkg::RPT_CNT;
          end
        end else begin
          d.gap = '0;
          if (ss_fall) begin
            // mode 3: first bit out as the frame opens
            d.sh   = q.fast ? rpt_byte(q.idx, q.rcnt, keys)
                            : tsh_pkg::IDLE_CODE;
            d.nb   = '0;
            d.miso = d.sh[7];
            d.moe  = 1'b1;
          end else if (sck && !q.sck_p && q.nb != tsh_pkg::NBITS) begin
            d.sh = {q.sh[6:0], q.s2[tsh_pkg::SY_MOSI]};
            d.nb = q.nb + 4'h1;
            done = (d.nb == tsh_pkg::NBITS);
          end else if (!sck && q.sck_p && q.nb != '0
                       && q.nb != tsh_pkg::NBITS) begin
            d.miso = q.sh[7];
          end
        end
        if (done) begin
          d.rxb = d.sh;
          d.rxv = 1'b1;
          if (q.fast) begin
            d.idx = (q.idx == tsh_pkg::RPT_LAST) ? tsh_pkg::RPT_CNT
                                                 : q.idx + 3'h1;
            if (q.idx == tsh_pkg::RPT_CNT) begin
              d.rcnt = (q.rcnt == tsh_pkg::CNT_MAX) ? '0
                                                    : q.rcnt + 8'h1;
            end
            if (q.idx == tsh_pkg::RPT_DETL) begin
              d.last = kd;
            end
          end
        end
        // decoder: fast mode knows two commands, no check byte
        if (cmd_v && q.fast) begin
          if (cmd == tsh_pkg::CMD_STORE) begin
            d.store = 1'b1;
          end else if (cmd == tsh_pkg::CMD_FULL) begin
            d.fast = 1'b0;
          end
        end else if (cmd_v) begin
          unique case (cmd)
            tsh_pkg::CMD_CAL:   d.recal = 1'b1;
            tsh_pkg::CMD_ALL:   d.last = kd;
            tsh_pkg::CMD_SLEEP: d.st = tsh_pkg::ST_SLEEP;
            tsh_pkg::CMD_RESET: begin
              d.st  = tsh_pkg::ST_INIT;
              d.tmr = '0;
            end
            default: ;
          endcase
        end
      end
    endcase
    // queue overflow set after the state logic so it beats the init clear
    if (q.rxv && !f_ready) begin
      d.ovr = 1'b1;
    end
    if (cfg.auto_recal && key_stuck && !q.stuck_p) begin
      d.recal = 1'b1;
    end
    // pin reset overrides every state and timer update and holds start-up open
    if (!q.s2[tsh_pkg::SY_RST]) begin
      d.st  = tsh_pkg::ST_INIT;
      d.tmr = '0;
    end
    // key mode; stand-alone forces seven keys
    d.m11  = cfg.mode11 && !cfg.standalone;
    d.trig = d.m11 && cfg.trig_sel;
    d.meas = (d.st == tsh_pkg::ST_RUN);
    d.slp  = (d.st == tsh_pkg::ST_SLEEP);
    // drop the data driver in the cycle the port leaves run, not one later
    d.moe  = d.moe && (d.st == tsh_pkg::ST_RUN);
    // change line recomputed from the updated snapshot so a release and a fresh change
    // in one cycle leave it released, the change taken into the new snapshot
    if (d.st == tsh_pkg::ST_SLEEP || d.st == tsh_pkg::ST_INIT) begin
      d.chg_oe = 1'b0;
    end else if (cfg.touch_mode) begin
      d.chg_oe = |kd;
    end else begin
      d.chg_oe = (kd != d.last);
    end
    // nine-level pwm: level 0 never high, level 8 always high
    d.pre = (q.pre == PRE_END) ? '0 : q.pre + 16'h1;
    if (q.pre == PRE_END) begin
      d.pwm = q.pwm + 3'h1;
    end
    for (int i = 0; i < tsh_pkg::NIND; i++) begin
      lvl_hit[i] = (keys.det[i] ? lvl_on[i] : lvl_off[i]) > {1'b0, q.pwm};
    end
    d.ind    = lvl_hit;
    d.ind_oe = (d.st == tsh_pkg::ST_RUN && !d.m11) ? '1 : '0;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      q      <= '0;
      q.s1   <= '1;
      q.s2   <= '1;
      q.sck_p <= 1'b1;
      q.ss_p <= 1'b1;
      q.chg_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register, except chg_o which is tied low
  assign miso_o    = q.miso;
  assign miso_oe   = q.moe;
  assign chg_o     = 1'b0;
  assign chg_oe    = q.chg_oe;
  assign meas_en   = q.meas;
  assign recal     = q.recal;
  assign ind_o     = q.ind;
  assign ind_oe    = q.ind_oe;
  assign fast_mode = q.fast;
  assign mode11    = q.m11;
  assign trig_sel  = q.trig;
  assign spi_ready = q.meas;
  assign nv_store  = q.store;
  assign overrun   = q.ovr;
  assign asleep    = q.slp;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence fast_done_s;
    done && q.fast;
  endsequence

  sequence wake_edge_s;
    q.st == tsh_pkg::ST_SLEEP && ss_fall && q.s2[tsh_pkg::SY_RST];
  endsequence

  ctr_range_a: assert property (q.rcnt <= tsh_pkg::CNT_MAX)
    else $error("report counter above 254");
  ctr_wrap_a: assert property (fast_done_s ##0 (q.idx == tsh_pkg::RPT_CNT
    && q.rcnt == tsh_pkg::CNT_MAX) |=> q.rcnt == '0)
    else $error("counter did not wrap to zero");
  idx_wrap_a: assert property (fast_done_s ##0 (q.idx == tsh_pkg::RPT_LAST
    && q.s2[tsh_pkg::SY_RST] && !cmd_v) |=> q.idx == tsh_pkg::RPT_CNT)
    else $error("report index did not wrap");
  idx_step_a: assert property (fast_done_s ##0 (q.idx < tsh_pkg::RPT_LAST)
    ##0 q.s2[tsh_pkg::SY_RST] |=> q.idx == $past(q.idx) + 3'h1)
    else $error("report index did not advance");
  full_cmd_a: assert property (cmd_v && q.fast && cmd == tsh_pkg::CMD_FULL
    && q.s2[tsh_pkg::SY_RST] |=> !q.fast)
    else $error("full mode command ignored");
  idle_restart_a: assert property (q.st == tsh_pkg::ST_RUN && !cfg.standalone
    && q.s2[tsh_pkg::SY_SS] && q.gap == IDLE_END && q.s2[tsh_pkg::SY_RST]
    |=> q.idx == tsh_pkg::RPT_CNT)
    else $error("report not restarted after pause");
  chg_touch_a: assert property (q.st == tsh_pkg::ST_RUN && cfg.touch_mode
    && |kd && q.s2[tsh_pkg::SY_RST] && !cmd_v |=> q.chg_oe)
    else $error("change line not low on touch");
  chg_data_a: assert property ((q.st == tsh_pkg::ST_RUN && !cfg.touch_mode
    && !cmd_v && !done && q.s2[tsh_pkg::SY_RST] && kd != q.last) [*2]
    |-> q.chg_oe)
    else $error("change line not low after key change");
  sleep_float_a: assert property (q.st == tsh_pkg::ST_SLEEP
    |-> q.ind_oe == '0 && !q.meas)
    else $error("indicators driven during sleep");
  wake_a: assert property (wake_edge_s |=> q.st == tsh_pkg::ST_WAKE
    ##1 q.st == tsh_pkg::ST_WAKE)
    else $error("no wake after select edge");
  init_quiet_a: assert property (q.st == tsh_pkg::ST_INIT |-> !q.moe
    ##1 !q.moe)
    else $error("serial output during start-up");
  pin_reset_a: assert property (!q.s2[tsh_pkg::SY_RST]
    |=> q.st == tsh_pkg::ST_INIT && q.tmr == '0)
    else $error("reset pin did not restart init");
endmodule
`default_nettype wire

// ### tb/tsh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsh_host_model (
  // serial pins toward the device
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  // link clock idles high and stands still between frames
  initial begin
    sck = 1'b1;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // one byte, mode 3, 125 ns link clock; select is held past the wake time
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    ss_n = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      mosi = tx[i];
      #62.5;
      sck = 1'b1;
      rx[i] = miso;
      #62.5;
    end
    #100;
    ss_n = 1'b1;
    mosi = ~mosi; // stale data must never look valid
    #300; // gap kept below the shortened idle timeout
  endtask
endmodule
`default_nettype wire

// ### tb/touch_sensor_host_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module touch_sensor_host_port_test;
  logic                 mclk = 1'b0, rst = 1'b1, reset_n = 1'b1, chg_low = 1'b0;
  logic                 nv_valid = 1'b0, nv_fast = 1'b0, key_stuck = 1'b0, oe_seen = 1'b0;
  logic                 sck, ss_n, mosi, miso_o, miso_oe, chg_o, chg_oe, chg_w;
  logic                 meas_en, recal, fast_mode, mode11, trig_sel, spi_ready;
  logic                 nv_store, overrun, asleep;
  logic [6:0]           ind_o, ind_oe;
  logic [6:0][3:0]      lvl_on = {7{4'h8}}, lvl_off = '0;
  logic [7:0]           rx;
  tsh_pkg::tsh_cfg_s    cfg = '0;
  tsh_pkg::tsh_keys_s   keys = '0;
  int                   err_count = 0, total_checks = 0, n_recal = 0, n_store = 0, hi;

  // open-drain change wire: low if either side pulls
  assign chg_w = (chg_oe || chg_low) ? 1'b0 : 1'b1;
  always #2.5 mclk = ~mclk;

  tsh_host_model host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso_oe ? miso_o : 1'bz));
  tsh_host_port #(.P_IDLE(200), .P_START(100), .P_WAKE(50), .P_PRE(2), .FDEPTH(4)) dut (
    .mclk(mclk), .rst(rst), .sck_i(sck), .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe), .chg_i(chg_w), .chg_o(chg_o), .chg_oe(chg_oe), .reset_n_i(reset_n),
    .cfg(cfg), .nv_valid(nv_valid), .nv_fast(nv_fast), .keys(keys), .key_stuck(key_stuck),
    .meas_en(meas_en), .recal(recal), .lvl_on(lvl_on), .lvl_off(lvl_off), .ind_o(ind_o),
    .ind_oe(ind_oe), .fast_mode(fast_mode), .mode11(mode11), .trig_sel(trig_sel),
    .spi_ready(spi_ready), .nv_store(nv_store), .overrun(overrun), .asleep(asleep));

  // pulses are one cycle wide, so they are counted rather than sampled
  always @(posedge mclk) begin
    if (recal === 1'b1) n_recal++;
    if (nv_store === 1'b1) n_store++;
    if (!ss_n && miso_oe === 1'b1) oe_seen = 1'b1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cmd(input logic [7:0] c);
    host.xfer(c, rx);
    cyc(5);
  endtask
  // expected report byte from the current key inputs
  function automatic logic [7:0] exp_byte(input int idx, input logic [7:0] cnt);
    logic [7:0] b;
    int         ch;
    b = (idx == 0) ? cnt : 8'h00;
    for (int j = 0; j < 4 && idx > 0; j++) begin
      ch = ((idx - 1) % 3) * 4 + j;
      if (ch > 10) b[2*j+:2] = 2'h0;
      else if (!keys.en[ch]) b[2*j+:2] = 2'h3;
      else if (idx < 4) b[2*j+:2] = keys.det[ch] ? 2'h1 : 2'h0;
      else b[2*j+:2] = keys.err[ch] ? 2'h2 : 2'h0;
    end
    return b;
  endfunction
  task automatic rd(input int idx, input logic [7:0] cnt);
    host.xfer(8'h00, rx);
    cyc(1);
    `CHK("report", exp_byte(idx, cnt), rx)
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #300000;
    err_count++;
    wrap_up;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(20);
    rst = 1'b0;
    cyc(50);
    `CHK("ready", 1'b0, spi_ready)
    cyc(60);
    `CHK("ready", 1'b1, spi_ready)
    keys = '{det: 11'h005, err: 11'h402, en: 11'h7FE};
    cfg.fast_cfg = 1'b1;
    cyc(3);
    `CHK("fast", 1'b1, fast_mode)
    for (int i = 0; i < 14; i++) rd(i % 7, 8'(i / 7));
    `CHK("chg", 1'b0, chg_oe)
    keys.det = 11'h00C;
    cyc(3);
    `CHK("chg", 1'b1, chg_oe)
    for (int i = 0; i < 4; i++) rd(i, 8'h02);
    cyc(3);
    `CHK("chg", 1'b0, chg_oe)
    cyc(250); // host pause longer than the idle timeout
    rd(0, 8'h03);
    cfg.touch_mode = 1'b1;
    cyc(3);
    `CHK("chg", 1'b1, chg_oe)
    keys.det = 11'h001; // only the disabled key in detect
    cyc(3);
    `CHK("chg", 1'b0, chg_oe)
    cmd(tsh_pkg::CMD_CAL);
    cmd(tsh_pkg::CMD_STORE);
    `CHK("store", 1, n_store)
    cmd(tsh_pkg::CMD_FULL);
    `CHK("fast", 1'b0, fast_mode)
    cmd(8'h00);
    `CHK("idle", tsh_pkg::IDLE_CODE, rx)
    cmd(tsh_pkg::CMD_CAL);
    `CHK("recal", 1, n_recal)
    // data mode in full command mode: a fresh touch holds the line until the report request
    cfg.touch_mode = 1'b0;
    keys.det = 11'h002;
    cyc(3);
    `CHK("chg", 1'b1, chg_oe)
    cmd(tsh_pkg::CMD_ALL);
    `CHK("chg", 1'b0, chg_oe)
    keys.det = 11'h001;
    cfg.touch_mode = 1'b1;
    cfg.auto_recal = 1'b1;
    key_stuck = 1'b1;
    cyc(4);
    `CHK("recal", 2, n_recal)
    `CHK("ind_oe", 7'h7F, ind_oe)
    repeat (20) begin cyc(1); `CHK("ind", 7'h01, ind_o) end
    lvl_on[0] = 4'h4;
    cyc(20);
    hi = 0;
    repeat (16) begin cyc(1); hi += int'(ind_o[0] === 1'b1); end
    `CHK("pwm", 8, hi)
    cmd(tsh_pkg::CMD_SLEEP);
    `CHK("sleep", 3'b100, {asleep, meas_en, |ind_oe})
    host.xfer(8'h00, rx);
    cyc(60);
    `CHK("wake", 4'b0110, {asleep, meas_en, |ind_oe, fast_mode})
    cmd(tsh_pkg::CMD_SLEEP);
    chg_low = 1'b1;
    cyc(60);
    chg_low = 1'b0;
    cyc(3);
    `CHK("asleep", 1'b0, asleep)
    cfg.mode11 = 1'b1;
    cfg.trig_sel = 1'b1;
    cyc(3);
    `CHK("mode11", 3'b110, {mode11, trig_sel, |ind_oe})
    nv_valid = 1'b1;
    nv_fast = 1'b1;
    cmd(tsh_pkg::CMD_RESET);
    `CHK("ready", 1'b0, spi_ready)
    cyc(110);
    `CHK("nv", 2'b11, {spi_ready, fast_mode})
    reset_n = 1'b0;
    cyc(5);
    `CHK("pin", 1'b0, spi_ready)
    reset_n = 1'b1;
    cyc(110);
    `CHK("pin", 2'b11, {spi_ready, fast_mode})
    cfg.standalone = 1'b1;
    cyc(3);
    oe_seen = 1'b0;
    host.xfer(8'h00, rx);
    cyc(1);
    `CHK("alone", 3'b001, {oe_seen, mode11, &ind_oe})
    `CHK("overrun", 1'b0, overrun)
    `CHK("chg_o", 1'b0, chg_o)
    wrap_up;
  end
endmodule
`default_nettype wire
